// ---- core/fdso_defs.vh ----
// Offsets, field positions, reset values and codes for the drive outputs
`ifndef FDSO_DEFS_VH
`define FDSO_DEFS_VH

// ==========================================================
// Register byte offsets
`define FDSO_ADDR_W         8
`define FDSO_OFF_DOR        8'h00
`define FDSO_OFF_DSR        8'h04
`define FDSO_OFF_CCR        8'h08
`define FDSO_OFF_FER        8'h0c
`define FDSO_OFF_FCR        8'h10
`define FDSO_OFF_MODE       8'h14
`define FDSO_OFF_PPM        8'h18
`define FDSO_OFF_STAT       8'h1c

// ==========================================================
// Field positions
`define FDSO_DOR_SEL_LO     0
`define FDSO_DOR_SEL_HI     1
`define FDSO_DOR_MTR_LO     4
`define FDSO_DOR_MTR_HI     7
`define FDSO_RATE_LO        0
`define FDSO_RATE_HI        1
`define FDSO_FER_ENC4       4
`define FDSO_FCR_SWAP       4
`define FDSO_MODE_DEN_LO    0
`define FDSO_MODE_DEN_HI    1
`define FDSO_PPM_EN         0
`define FDSO_PPM_PNF        1

// ==========================================================
// Reset values
`define FDSO_RST_DOR        8'h00
`define FDSO_RST_RATE       2'h0
`define FDSO_RST_FER        8'h00
`define FDSO_RST_FCR        8'h00
`define FDSO_RST_MODE       2'h0
`define FDSO_RST_PPM        2'h0

// ==========================================================
// Data rate codes (2'h3 is 1 Mbps, or 2 Mbps on tape drives)
`define FDSO_RATE_500K      2'h0
`define FDSO_RATE_300K      2'h1
`define FDSO_RATE_250K      2'h2
`define FDSO_RATE_1M        2'h3

// ==========================================================
// Density mode codes set by the mode command
`define FDSO_DEN_AUTO       2'h0
`define FDSO_DEN_LOW        2'h1
`define FDSO_DEN_HIGH       2'h2
`define FDSO_DEN_AUTO2      2'h3

`endif

// ---- core/fdso_sync.v ----
// Two-stage synchroniser for inputs arriving from pins
`timescale 1ns/100ps

module fdso_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             core_clk,
   input  wire             rst,
   // Asynchronous input and its synchronised copy
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta;

   // ==========================================================
   // Synchroniser stages
   // The first stage feeds only the second, never any logic
   always @(posedge core_clk) begin
      if (rst) begin
         meta     <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

// ---- core/fdso_top.v ----
// Floppy drive select, density and direction outputs with APB registers
//
// Overview of operation
// - High density at 500k, 1M, 2M rates
// - Density polarity follows drive-type input level
// - Mode command can force density select
// - Copy density on parallel pin in mode
// - Direction active steps in, inactive out
// - Direction inactive during reads and writes
// - Copy direction on parallel pin in mode
// - Drive select decoded from output register bits
// - Select gated by per-drive motor enables
// - Drive selects are active low
// - Enable-register bit 4 encodes four drives
// - Control-register bit 4 swaps drives zero, one
// - Parallel select pin follows swap bit
// - Rate from last written rate register
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "fdso_defs.vh"

module fdso_top (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Command engine state
   input  wire        seek_active,
   input  wire        seek_inward,
   input  wire        rw_active,
   // Drive type pin
   input  wire        drive_type_ident,
   // Floppy drive outputs
   output reg         density_select_out,
   output reg         head_dir_n,
   output reg         drive_select_a_n,
   output reg         drive_select_b_n,
   output reg         drive_encoded,
   // Parallel port copies
   output reg         ppm_pins_active,
   output reg         ppm_density_out,
   output reg         ppm_head_dir_n,
   output reg         ppm_drive_select_n
);

   // ==========================================================
   // Register storage
   reg  [7:0] digital_output_reg;
   reg  [1:0] dsr_rate;
   reg  [1:0] ccr_rate;
   reg  [1:0] cur_rate;
   reg  [7:0] function_enable_reg;
   reg  [7:0] function_control_reg;
   reg  [1:0] density_mode;
   reg        parallel_port_floppy_mode;
   reg        parallel_floppy_config_bit;

   // ==========================================================
   // Bus decode signals
   wire       setup_phase;
   wire       write_en;
   reg        addr_hit;
   reg [31:0] next_prdata;

   // ==========================================================
   // Drive side combinational values
   wire       ident_sync;
   wire [1:0] sel_logical;
   wire       sel_motor_on;
   wire [3:0] motor_en;
   reg  [1:0] sel_physical;
   reg        rate_high;
   reg        density_high;
   reg        next_density;
   reg        next_dir_n;
   reg        next_sel_a_n;
   reg        next_sel_b_n;
   reg        next_encoded;
   wire       ppm_on;

   // ==========================================================
   // Drive type pin synchroniser
   // The pin is strapped or driven from the drive cable, so it
   // is not on the controller clock
   // Cost: the type takes effect two edges late, harmless for
   // a strap that only changes with the drive
   fdso_sync #(
      .WIDTH (1)
   ) u_ident_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (drive_type_ident),
      .sync_out (ident_sync)
   );

   // ==========================================================
   // APB phase decode
   // A write lands only on the access edge where pready is high
   assign setup_phase = psel & ~penable;
   assign write_en    = psel & penable & pwrite & pready;

   // Address hit and read mux, evaluated in the setup phase
   // Unmapped offsets read as zero and raise pslverr
   always @* begin
      addr_hit    = 1'b1;
      next_prdata = 32'h0000_0000;
      if (paddr == `FDSO_OFF_DOR) begin
         next_prdata[7:0] = digital_output_reg;
      end else if (paddr == `FDSO_OFF_DSR) begin
         next_prdata[1:0] = dsr_rate;
      end else if (paddr == `FDSO_OFF_CCR) begin
         next_prdata[1:0] = ccr_rate;
      end else if (paddr == `FDSO_OFF_FER) begin
         next_prdata[7:0] = function_enable_reg;
      end else if (paddr == `FDSO_OFF_FCR) begin
         next_prdata[7:0] = function_control_reg;
      end else if (paddr == `FDSO_OFF_MODE) begin
         next_prdata[1:0] = density_mode;
      end else if (paddr == `FDSO_OFF_PPM) begin
         next_prdata[`FDSO_PPM_EN]  = parallel_port_floppy_mode;
         next_prdata[`FDSO_PPM_PNF] = parallel_floppy_config_bit;
      end else if (paddr == `FDSO_OFF_STAT) begin
         // Live view of what the drive cable sees
         next_prdata[1:0] = cur_rate;
         next_prdata[2]   = density_select_out;
         next_prdata[3]   = head_dir_n;
         next_prdata[4]   = drive_select_a_n;
         next_prdata[5]   = drive_select_b_n;
         next_prdata[6]   = ident_sync;
         next_prdata[7]   = ppm_pins_active;
         next_prdata[8]   = drive_encoded;
      end else begin
         addr_hit = 1'b0;
      end
   end

   // ==========================================================
   // APB answer
   // Always one wait-free access cycle: pready is set from the
   // setup cycle so the access phase completes at its first edge
   // pslverr only rises beside pready, so a master that ignores
   // errors still sees every transfer end
   always @(posedge core_clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase & ~addr_hit;
         if (setup_phase & ~pwrite) begin
            prdata <= next_prdata;
         end else if (~psel) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // Register writes
   // Unmapped writes are answered with pslverr and change nothing
   // Only the listed low bits are stored; the rest reads as zero.
   // Writes to the status word are ignored without an error
   always @(posedge core_clk) begin
      if (rst) begin
         digital_output_reg         <= `FDSO_RST_DOR;
         dsr_rate                   <= `FDSO_RST_RATE;
         ccr_rate                   <= `FDSO_RST_RATE;
         function_enable_reg        <= `FDSO_RST_FER;
         function_control_reg       <= `FDSO_RST_FCR;
         density_mode               <= `FDSO_RST_MODE;
         parallel_port_floppy_mode  <= 1'b0;
         parallel_floppy_config_bit <= 1'b0;
      end else if (write_en) begin
         if (paddr == `FDSO_OFF_DOR) begin
            digital_output_reg <= pwdata[7:0];
         end else if (paddr == `FDSO_OFF_DSR) begin
            dsr_rate <= pwdata[`FDSO_RATE_HI:`FDSO_RATE_LO];
         end else if (paddr == `FDSO_OFF_CCR) begin
            ccr_rate <= pwdata[`FDSO_RATE_HI:`FDSO_RATE_LO];
         end else if (paddr == `FDSO_OFF_FER) begin
            function_enable_reg <= pwdata[7:0];
         end else if (paddr == `FDSO_OFF_FCR) begin
            function_control_reg <= pwdata[7:0];
         end else if (paddr == `FDSO_OFF_MODE) begin
            density_mode <= pwdata[`FDSO_MODE_DEN_HI:`FDSO_MODE_DEN_LO];
         end else if (paddr == `FDSO_OFF_PPM) begin
            parallel_port_floppy_mode  <= pwdata[`FDSO_PPM_EN];
            parallel_floppy_config_bit <= pwdata[`FDSO_PPM_PNF];
         end
      end
   end

   // ==========================================================
   // Current data rate
   // last written rate wins
   // Both registers feed one rate; whichever was written last
   // owns it, so software need not keep the two in step
   always @(posedge core_clk) begin
      if (rst) begin
         cur_rate <= `FDSO_RST_RATE;
      end else if (write_en & ((paddr == `FDSO_OFF_DSR) |
                               (paddr == `FDSO_OFF_CCR))) begin
         cur_rate <= pwdata[`FDSO_RATE_HI:`FDSO_RATE_LO];
      end
   end

   // ==========================================================
   // Density select
   always @* begin
      rate_high = (cur_rate == `FDSO_RATE_500K) |
                  (cur_rate == `FDSO_RATE_1M);
      // Codes 1 and 2 force the line; 0 and 3 leave it to the rate
      // software override
      if (density_mode == `FDSO_DEN_LOW) begin
         density_high = 1'b0;
      end else if (density_mode == `FDSO_DEN_HIGH) begin
         density_high = 1'b1;
      end else begin
         density_high = rate_high;
      end
      next_density = ident_sync ? density_high : ~density_high;
   end

   // ==========================================================
   // Head direction, active low on the cable
   // Read/write wins over seek so a seek flag left standing by the
   // command engine can never step the head during a transfer
   always @* begin
      if (rw_active) begin
         next_dir_n = 1'b1;
      end else if (seek_active) begin
         next_dir_n = ~seek_inward;
      end else begin
         next_dir_n = 1'b1;
      end
   end

   // ==========================================================
   // Drive select
   // select field decode
   assign sel_logical  = digital_output_reg[`FDSO_DOR_SEL_HI:
                                            `FDSO_DOR_SEL_LO];
   // One enable bit per logical drive; a part-select keeps the
   // index exactly as wide as the select field
   // motor enable gating
   assign motor_en     = digital_output_reg[`FDSO_DOR_MTR_HI:
                                            `FDSO_DOR_MTR_LO];
   assign sel_motor_on = motor_en[sel_logical];

   always @* begin
      // swap drives zero and one
      // Only the first two drives trade places; the motor enable
      // still follows the logical drive that software picked
      sel_physical = sel_logical;
      if (function_control_reg[`FDSO_FCR_SWAP] &
          ~sel_logical[1]) begin
         sel_physical = {1'b0, ~sel_logical[0]};
      end
      // In plain mode drives 2 and 3 have no line and stay idle
      next_encoded = 1'b0;
      next_sel_a_n = 1'b1;
      next_sel_b_n = 1'b1;
      if (sel_motor_on) begin
         // four-drive encoding
         // The drive number goes out inverted and drive_encoded
         // qualifies it, since drive 0 alone would look idle
         if (function_enable_reg[`FDSO_FER_ENC4]) begin
            next_encoded = 1'b1;
            next_sel_a_n = ~sel_physical[0];
            next_sel_b_n = ~sel_physical[1];
         end else if (sel_physical == 2'h0) begin
            next_sel_a_n = 1'b0;
         end else if (sel_physical == 2'h1) begin
            next_sel_b_n = 1'b0;
         end
      end
   end

   // ==========================================================
   // Parallel port floppy copies
   // Limitation: the copies are valid only while ppm_pins_active
   // is high; otherwise they rest at their idle levels
   // enable for parallel copies
   assign ppm_on = parallel_port_floppy_mode &
                   ~parallel_floppy_config_bit;

   // ==========================================================
   // Output flops
   // registered, deselected on reset
   // Everything leaves through a flop so the cable never sees
   // decode glitches when several register bits change at once
   // The parallel copies take the same next values as the cable
   // lines, so both pins move on the same edge
   always @(posedge core_clk) begin
      if (rst) begin
         density_select_out <= 1'b0;
         head_dir_n         <= 1'b1;
         drive_select_a_n   <= 1'b1;
         drive_select_b_n   <= 1'b1;
         drive_encoded      <= 1'b0;
         ppm_pins_active    <= 1'b0;
         ppm_density_out    <= 1'b0;
         ppm_head_dir_n     <= 1'b1;
         ppm_drive_select_n <= 1'b1;
      end else begin
         density_select_out <= next_density;
         head_dir_n         <= next_dir_n;
         drive_select_a_n   <= next_sel_a_n;
         drive_select_b_n   <= next_sel_b_n;
         drive_encoded      <= next_encoded;
         ppm_pins_active    <= ppm_on;
         ppm_density_out    <= ppm_on & next_density;
         ppm_head_dir_n     <= ~ppm_on | next_dir_n;
         // After a swap the extra pin tracks line A, else line B
         // select copy follows swap
         if (~ppm_on) begin
            ppm_drive_select_n <= 1'b1;
         end else if (function_control_reg[`FDSO_FCR_SWAP]) begin
            ppm_drive_select_n <= next_sel_a_n;
         end else begin
            ppm_drive_select_n <= next_sel_b_n;
         end
      end
   end

endmodule

// ---- testbench/fdso_drive_model.sv ----
// Floppy drive cable model: type pin and which drive sees itself selected
`timescale 1ns/100ps

module fdso_drive_model (
   // Select lines from the controller
   input  wire        drive_select_a_n,
   input  wire        drive_select_b_n,
   input  wire        drive_encoded,
   // Drive kind chosen by the bench, 1 for the high type
   input  wire        drive_kind_hi,
   // Lines back to the controller and the bench
   output wire        drive_type_ident,
   output logic [2:0] selected_drive
);
   // Type pin is a static strap of the drive
   assign drive_type_ident = drive_kind_hi;

   // Encoded cable needs an external decoder; 3'h4 means nobody
   always_comb begin
      if (drive_encoded)
         selected_drive = {1'b0, ~drive_select_b_n, ~drive_select_a_n};
      else if (!drive_select_a_n)
         selected_drive = 3'h0;
      else if (!drive_select_b_n)
         selected_drive = 3'h1;
      else
         selected_drive = 3'h4;
   end
endmodule

// ---- testbench/fdso_top_monitor.sv ----
// Concurrent checks on the drive outputs and the APB answer of fdso_top
`timescale 1ns/100ps

module fdso_top_monitor (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // APB handshake
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   // Command engine state
   input wire seek_active,
   input wire seek_inward,
   input wire rw_active,
   // Drive cable lines
   input wire density_select_out,
   input wire head_dir_n,
   input wire drive_select_a_n,
   input wire drive_select_b_n,
   input wire drive_encoded,
   // Parallel port copies
   input wire ppm_pins_active,
   input wire ppm_density_out,
   input wire ppm_head_dir_n
);
   // ==========================================================
   // Shared clocking; all checks sleep while reset is high
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Steps of one bus transfer
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence

   // ==========================================================
   // Bus answer: no wait states, error only with ready
   a_apb_answer: assert property (s_setup |=> s_access)
      else $error("access phase did not complete after setup");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   // Head direction follows seek and read/write state
   a_dir_inward: assert property (seek_active && seek_inward && !rw_active
      |=> !head_dir_n)
      else $error("direction not active on inward seek");
   a_dir_outward: assert property (seek_active && !seek_inward
      |=> head_dir_n)
      else $error("direction active on outward seek");
   a_dir_rw: assert property (rw_active |=> head_dir_n)
      else $error("direction active during read or write");
   // At most one plain select low at a time
   a_sel_single: assert property (!drive_encoded
      |-> drive_select_a_n || drive_select_b_n)
      else $error("two drives selected in plain mode");
   a_reset_safe: assert property ($fell(rst) |-> drive_select_a_n
      && drive_select_b_n && head_dir_n && !drive_encoded)
      else $error("outputs not in safe state after reset");
   // Parallel copies: idle levels, and mirror of steady lines
   a_ppm_idle: assert property (!ppm_pins_active && !$past(ppm_pins_active)
      |-> !ppm_density_out && ppm_head_dir_n)
      else $error("parallel copies not idle");
   a_ppm_dir: assert property (ppm_pins_active && $past(ppm_pins_active)
      && $stable(head_dir_n) |-> ppm_head_dir_n == head_dir_n)
      else $error("parallel direction copy differs");
   a_ppm_den: assert property (ppm_pins_active && $past(ppm_pins_active)
      && $stable(density_select_out)
      |-> ppm_density_out == density_select_out)
      else $error("parallel density copy differs");
endmodule

bind fdso_top fdso_top_monitor u_mon (
   .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .seek_active(seek_active),
   .seek_inward(seek_inward), .rw_active(rw_active),
   .density_select_out(density_select_out), .head_dir_n(head_dir_n),
   .drive_select_a_n(drive_select_a_n), .drive_select_b_n(drive_select_b_n),
   .drive_encoded(drive_encoded), .ppm_pins_active(ppm_pins_active),
   .ppm_density_out(ppm_density_out), .ppm_head_dir_n(ppm_head_dir_n)
);

// ---- testbench/fdso_top_tb.sv ----
// Self-checking bench for the floppy drive select outputs
`timescale 1ns/100ps
`include "fdso_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module fdso_top_tb;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [3:0] e;
   } fdso_row_t;
   logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, seek_active = 1'b0, seek_inward = 1'b0;
   logic        rw_active = 1'b0, drive_kind_hi = 1'b1, pready, pslverr, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0]  selected_drive;
   wire         drive_type_ident, den, dir_n, sel_a_n, sel_b_n, enc;
   wire         ppm_on, ppm_den, ppm_dir_n, ppm_sel_n;
   int          fails = 0, total_checks = 0;
   // Writes build on each other; expected {density, sel a, sel b, encoded}
   fdso_row_t rows [22] = '{
      '{`FDSO_OFF_DOR, 8'h10, 4'ha}, '{`FDSO_OFF_DOR, 8'h21, 4'hc},
      '{`FDSO_OFF_DOR, 8'h20, 4'he}, '{`FDSO_OFF_DOR, 8'h11, 4'he},
      '{`FDSO_OFF_FCR, 8'h10, 4'he}, '{`FDSO_OFF_DOR, 8'h10, 4'hc},
      '{`FDSO_OFF_DOR, 8'h21, 4'ha}, '{`FDSO_OFF_FCR, 8'h00, 4'hc},
      '{`FDSO_OFF_DOR, 8'hf2, 4'he}, '{`FDSO_OFF_FER, 8'h10, 4'hd},
      '{`FDSO_OFF_DOR, 8'hf3, 4'h9}, '{`FDSO_OFF_FER, 8'h00, 4'he},
      '{`FDSO_OFF_DSR, 8'h01, 4'h6}, '{`FDSO_OFF_DSR, 8'h02, 4'h6},
      '{`FDSO_OFF_DSR, 8'h03, 4'he}, '{`FDSO_OFF_CCR, 8'h02, 4'h6},
      '{`FDSO_OFF_DSR, 8'h00, 4'he}, '{`FDSO_OFF_MODE, 8'h01, 4'h6},
      '{`FDSO_OFF_MODE, 8'h02, 4'he}, '{`FDSO_OFF_CCR, 8'h01, 4'he},
      '{`FDSO_OFF_MODE, 8'h03, 4'h6}, '{`FDSO_OFF_MODE, 8'h00, 4'h6}};

   // ==========================================================
   // Clock, design and drive model
   always #20 core_clk = ~core_clk;

   fdso_top DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .seek_active(seek_active), .seek_inward(seek_inward),
      .rw_active(rw_active), .drive_type_ident(drive_type_ident),
      .density_select_out(den), .head_dir_n(dir_n),
      .drive_select_a_n(sel_a_n), .drive_select_b_n(sel_b_n),
      .drive_encoded(enc), .ppm_pins_active(ppm_on),
      .ppm_density_out(ppm_den), .ppm_head_dir_n(ppm_dir_n),
      .ppm_drive_select_n(ppm_sel_n));

   fdso_drive_model u_drives (.drive_select_a_n(sel_a_n),
      .drive_select_b_n(sel_b_n), .drive_encoded(enc),
      .drive_kind_hi(drive_kind_hi), .drive_type_ident(drive_type_ident),
      .selected_drive(selected_drive));

   // ==========================================================
   // Tasks
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // One APB transfer, then an idle edge so psel is never set twice at once
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // A hang counts as a mismatch
   initial begin
      tick(5000);
      fails++;
      print_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      tick(3);
      rst <= 1'b0;
      tick(1);
      `CHK({sel_a_n, sel_b_n, dir_n, enc, ppm_on}, 5'h1c)
      tick(3);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, {24'h0, rows[i].d});
         tick(3);
         `CHK({den, sel_a_n, sel_b_n, enc}, rows[i].e)
         if (i == 10)
            `CHK(selected_drive, 3'h3)
      end
      // Rate registers keep their own values; bad address errors
      apb(1'b0, `FDSO_OFF_CCR, 32'h0);
      `CHK(rd, 32'h1)
      apb(1'b0, 8'h20, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, `FDSO_OFF_STAT, 32'hff);
      `CHK(err, 1'b0)
      // Status word: 300k, low density, nothing selected, high type
      apb(1'b0, `FDSO_OFF_STAT, 32'h0);
      `CHK(rd, 32'h79)
      // Low-type drive flips the density line (300k is low density)
      drive_kind_hi <= 1'b0;
      tick(6);
      `CHK(den, 1'b1)
      drive_kind_hi <= 1'b1;
      // Seek in, then a read overrides, then seek out
      seek_active <= 1'b1;
      seek_inward <= 1'b1;
      tick(2);
      `CHK(dir_n, 1'b0)
      rw_active <= 1'b1;
      tick(2);
      `CHK(dir_n, 1'b1)
      rw_active <= 1'b0;
      seek_inward <= 1'b0;
      tick(2);
      `CHK(dir_n, 1'b1)
      // Parallel copies with the config bit clear, then set
      seek_inward <= 1'b1;
      apb(1'b1, `FDSO_OFF_DSR, 32'h0);
      apb(1'b1, `FDSO_OFF_PPM, 32'h1);
      apb(1'b1, `FDSO_OFF_DOR, 32'h21);
      tick(3);
      `CHK({ppm_on, ppm_den, ppm_dir_n, ppm_sel_n}, 4'hc)
      apb(1'b1, `FDSO_OFF_FCR, 32'h10);
      apb(1'b1, `FDSO_OFF_DOR, 32'h10);
      tick(3);
      `CHK(ppm_sel_n, 1'b1)
      apb(1'b1, `FDSO_OFF_PPM, 32'h3);
      tick(3);
      `CHK({ppm_on, ppm_den, ppm_dir_n, ppm_sel_n}, 4'h3)
      // Reset in mid-seek with a drive selected
      rst <= 1'b1;
      tick(3);
      rst <= 1'b0;
      tick(1);
      `CHK({sel_a_n, sel_b_n, dir_n}, 3'h7)
      apb(1'b0, `FDSO_OFF_DSR, 32'h0);
      `CHK(rd, 32'h0)
      print_verdict();
   end
endmodule
